// ===== verilog/acei_pkg.sv
package acei_pkg;
    localparam int ACEI_AW = 4;
    localparam int ACEI_RES_W = 10;
    // Register byte offsets
    localparam logic [ACEI_AW-1:0] ACEI_CTRL_OFS = 4'h0;
    localparam logic [ACEI_AW-1:0] ACEI_RESULT_OFS = 4'h4;
    localparam logic [ACEI_AW-1:0] ACEI_CHAN_OFS = 4'h8;
    // Control/status bit positions
    localparam int ACEI_FLAG_BIT = 7;
    localparam int ACEI_IEN_BIT = 6;
    localparam int ACEI_START_BIT = 5;
    localparam int ACEI_SCAN_BIT = 4;
    localparam int ACEI_CH_LSB = 0;
    localparam int ACEI_CH_W = 3;
    localparam logic [ACEI_CH_W-1:0] ACEI_CH_MAX = 3'h7;
    localparam logic [ACEI_RES_W-1:0] ACEI_RES_ZERO = 10'h000;
    localparam logic [ACEI_RES_W-1:0] ACEI_RES_FULL = 10'h3FF;
    // Conversion time in cycles per channel
    localparam logic [8:0] ACEI_CONV_CYC = 9'h050;
    typedef enum logic [1:0] {
        ACEI_IDLE = 2'b00,
        ACEI_CONV = 2'b01,
        ACEI_DONE = 2'b11
    } acei_state_type;
endpackage : acei_pkg

// ===== verilog/acei_top.sv
module acei_top
    import acei_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic module_stop,
    input wire logic standby,
    input wire logic [ACEI_RES_W-1:0] analog_code,
    output logic conv_end_irq
);
    acei_state_type state_q, state_d;
    logic [7:0] csr_q;
    logic [ACEI_RES_W-1:0] result_q [0:7];
    logic [ACEI_CH_W-1:0] cur_ch_q;
    logic [8:0] cnt_q;
    logic flag_seen_q;
    logic [1:0] stop_sync_q, stby_sync_q;
    logic [ACEI_RES_W-1:0] code_s1_q, code_s2_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic irq_q;

    wire stopped = stop_sync_q[1];
    wire frozen = stby_sync_q[1];
    wire req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire acc_ok = req & ~stopped;
    wire sel_ctrl = wb_adr_i[ACEI_AW-1:0] == ACEI_CTRL_OFS;
    wire sel_res = wb_adr_i[ACEI_AW-1:0] == ACEI_RESULT_OFS;
    wire sel_chan = wb_adr_i[ACEI_AW-1:0] == ACEI_CHAN_OFS;
    wire wr_ctrl = acc_ok & wb_we_i & wb_sel_i[0] & sel_ctrl;
    wire rd_ctrl = acc_ok & ~wb_we_i & sel_ctrl;
    wire start = csr_q[ACEI_START_BIT];
    wire scan = csr_q[ACEI_SCAN_BIT];
    wire [ACEI_CH_W-1:0] ch_sel = csr_q[ACEI_CH_LSB +: ACEI_CH_W];
    wire [ACEI_CH_W-1:0] group_first = scan ? {ch_sel[2], 2'b00} : ch_sel;
    wire [ACEI_CH_W-1:0] group_last = scan ? {ch_sel[2], 2'b11} : ch_sel;
    // Standby and module stop both hold off the end of a conversion
    wire conv_fin = (state_q == ACEI_CONV) & (cnt_q == ACEI_CONV_CYC) & ~frozen
                    & ~stopped;
    wire group_done = conv_fin & (cur_ch_q == group_last);
    // Flag cleared by writing 0 only after it was read as 1
    wire flag_clr = wr_ctrl & ~wb_dat_i[ACEI_FLAG_BIT] & flag_seen_q;
    wire [7:0] wmask = 8'h7F;
    wire [7:0] csr_wr = (csr_q & ~wmask) | (wb_dat_i[7:0] & wmask);
    wire [ACEI_RES_W-1:0] ch_result = result_q[wb_adr_i[ACEI_CH_W+3:4]];
    wire [31:0] rd_mux = sel_ctrl ? {24'h000000, csr_q} :
                         sel_res ? {22'h000000, result_q[ch_sel]} :
                         sel_chan ? {22'h000000, ch_result} : 32'h00000000;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ACEI_IDLE: if (start & ~frozen & ~stopped) state_d = ACEI_CONV;
            ACEI_CONV: begin
                // Module stop aborts a running conversion so the block sits inactive
                if (~start | stopped) state_d = ACEI_IDLE;
                else if (group_done) state_d = ACEI_DONE;
            end
            ACEI_DONE: state_d = (scan & start & ~stopped) ? ACEI_CONV : ACEI_IDLE;
            default: state_d = ACEI_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            stop_sync_q <= 2'b11;
            stby_sync_q <= 2'b00;
            code_s1_q <= ACEI_RES_ZERO;
            code_s2_q <= ACEI_RES_ZERO;
        end else begin
            stop_sync_q <= {stop_sync_q[0], module_stop};
            stby_sync_q <= {stby_sync_q[0], standby};
            code_s1_q <= analog_code;
            code_s2_q <= code_s1_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= ACEI_IDLE;
            cnt_q <= '0;
            cur_ch_q <= '0;
        end else if (!frozen) begin
            state_q <= state_d;
            cnt_q <= (state_q == ACEI_CONV && !conv_fin) ? cnt_q + 9'h001 : 9'h001;
            if (state_q != ACEI_CONV || group_done) cur_ch_q <= group_first;
            else if (conv_fin) cur_ch_q <= cur_ch_q + 3'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i <= ACEI_CH_MAX; i++) result_q[i] <= ACEI_RES_ZERO;
        end else if (conv_fin && start) begin
            result_q[cur_ch_q] <= code_s2_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            csr_q <= 8'h00;
            flag_seen_q <= 1'b0;
        end else begin
            if (wr_ctrl) csr_q <= csr_wr;
            // Set beats clear when both land in one cycle
            if (group_done && start) csr_q[ACEI_FLAG_BIT] <= 1'b1;
            else if (flag_clr) csr_q[ACEI_FLAG_BIT] <= 1'b0;
            else if (wr_ctrl) csr_q[ACEI_FLAG_BIT] <= csr_q[ACEI_FLAG_BIT];
            if (group_done && start && !scan && !(wr_ctrl && !wb_dat_i[ACEI_START_BIT])) begin
                csr_q[ACEI_START_BIT] <= 1'b0;
            end
            if (rd_ctrl && csr_q[ACEI_FLAG_BIT]) flag_seen_q <= 1'b1;
            else if (flag_clr) flag_seen_q <= 1'b0;
        end
    end

    // Ack is a one-cycle pulse; req masks a second take while it stands
    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // Read data stands only with ack, so the bus sees zero between transfers
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= acc_ok ? rd_mux : 32'h00000000;
        end
    end

    // Registered, so the request lags flag and enable by one cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= csr_q[ACEI_FLAG_BIT] & csr_q[ACEI_IEN_BIT];
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign conv_end_irq = irq_q;

    a_irq_follows: assert property (@(posedge mclk) disable iff (rst)
        conv_end_irq == $past(csr_q[ACEI_FLAG_BIT] & csr_q[ACEI_IEN_BIT]))
        else $error("irq does not follow flag and enable");
    a_flag_on_done: assert property (@(posedge mclk) disable iff (rst)
        group_done && start |=> csr_q[ACEI_FLAG_BIT])
        else $error("flag not set at conversion end");
    a_stop_blocks: assert property (@(posedge mclk) disable iff (rst)
        stopped && req |=> wb_dat_o == 32'h00000000 && $stable(csr_q))
        else $error("register access during module stop");
    a_freeze_keeps: assert property (@(posedge mclk) disable iff (rst)
        frozen && !wr_ctrl |=> $stable(csr_q) && $stable(state_q))
        else $error("state changed in standby");
    a_single_clears: assert property (@(posedge mclk) disable iff (rst)
        group_done && start && !scan && !wr_ctrl |=> !csr_q[ACEI_START_BIT])
        else $error("start bit not cleared in single mode");
    a_scan_restart: assert property (@(posedge mclk) disable iff (rst)
        group_done && scan && start && !wr_ctrl && !frozen |=>
        ##1 (state_q == ACEI_CONV || $past(frozen || stopped)))
        else $error("scan did not restart");
    a_flag_sticky: assert property (@(posedge mclk) disable iff (rst)
        csr_q[ACEI_FLAG_BIT] && !flag_clr |=> csr_q[ACEI_FLAG_BIT])
        else $error("flag dropped without clear");
    a_ack_one: assert property (@(posedge mclk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    // Module stop, bus and conversion guards
    a_reset_stopped: assert property (@(posedge mclk)
        $past(rst) && !rst |-> stopped)
        else $error("block not in module stop after reset");
    a_stop_idle: assert property (@(posedge mclk) disable iff (rst)
        stopped && state_q != ACEI_CONV |=> state_q != ACEI_CONV)
        else $error("conversion started during module stop");
    a_ack_always: assert property (@(posedge mclk) disable iff (rst)
        req |=> wb_ack_o)
        else $error("request not acknowledged");
    a_idle_data: assert property (@(posedge mclk) disable iff (rst)
        !wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data outside ack");
    a_result_stored: assert property (@(posedge mclk) disable iff (rst)
        conv_fin && start |=> result_q[$past(cur_ch_q)] == $past(code_s2_q))
        else $error("result not stored at conversion end");
    a_scan_keeps_start: assert property (@(posedge mclk) disable iff (rst)
        group_done && start && scan && !wr_ctrl |=> csr_q[ACEI_START_BIT])
        else $error("start bit cleared in scan mode");
    a_flag_clear: assert property (@(posedge mclk) disable iff (rst)
        flag_clr && !(group_done && start) |=> !csr_q[ACEI_FLAG_BIT])
        else $error("flag not cleared by write of zero");
    a_freeze_count: assert property (@(posedge mclk) disable iff (rst)
        frozen |=> $stable(cnt_q) && $stable(cur_ch_q))
        else $error("converter moved in standby");
    c_single_end: cover property (@(posedge mclk) group_done && !scan);
    c_scan_end: cover property (@(posedge mclk) group_done && scan);
    c_irq: cover property (@(posedge mclk) $rose(conv_end_irq));
    c_stop_access: cover property (@(posedge mclk) stopped && req);
    c_freeze: cover property (@(posedge mclk) frozen && state_q == ACEI_CONV);
endmodule : acei_top

// ===== bench/acei_xfer_model.sv
module acei_xfer_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic conv_end_irq,
    output int act_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic irq_q;
    // A level request stands until the flag is cleared, so count only fresh ones
    always_ff @(posedge mclk) begin
        irq_q <= rst ? 1'h0 : conv_end_irq;
        if (rst) act_count <= 0;
        else if (conv_end_irq && !irq_q) act_count <= act_count + 1;
    end
endmodule : acei_xfer_model

// ===== bench/tb_adc_conversion_end_interrupt.sv
module tb_adc_conversion_end_interrupt
    import acei_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst = 1, wb_we = 0, wb_cyc = 0, wb_stb = 0, mstop = 1, stby = 0;
    logic [31:0] wb_adr = 0, wb_dat = 0, rd, wb_dat_o;
    logic [9:0] code = 0;
    logic wb_ack_o, irq;
    int failures = 0, total_checks = 0, cycles = 0, acts;
    always #2.5 mclk = ~mclk;
    acei_top dut_u (.mclk(mclk), .rst(rst), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_sel_i(4'hF), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_ack_o(wb_ack_o), .module_stop(mstop), .standby(stby),
        .analog_code(code), .conv_end_irq(irq));
    acei_xfer_model xfer_u (.mclk(mclk), .rst(rst), .conv_end_irq(irq), .act_count(acts));
    task automatic complete_run();
        $display("failures=%0d total_checks=%0d", failures, total_checks);
        if (failures == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= we;
        wb_adr <= {24'h000000, adr};
        wb_dat <= dat;
        do begin
            @(posedge mclk);
        end while (wb_ack_o !== 1'h1);
        rd = wb_dat_o;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        @(posedge mclk);
    endtask : bus
    task automatic wait_flag();
        do begin
            bus(1'h0, 8'h00, 32'h0);
        end while (rd[7] !== 1'h1);
    endtask : wait_flag
    task automatic t_stop();
        bus(1'h1, 8'h00, 32'h00000070);
        bus(1'h0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        mstop <= 1'h0;
        repeat (4) @(posedge mclk);
        bus(1'h0, 8'h00, 32'h0);
        chk(rd, 32'h0);
    endtask : t_stop
    task automatic t_single();
        code <= ACEI_RES_FULL;
        bus(1'h1, 8'h00, 32'h00000021);
        wait_flag();
        chk(rd, 32'h00000081);
        chk({31'h0, irq}, 32'h0);
        bus(1'h0, 8'h18, 32'h0);
        chk(rd, {22'h0, ACEI_RES_FULL});
        bus(1'h1, 8'h00, 32'h000000C1);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        chk(acts, 1);
        bus(1'h0, 8'h00, 32'h0);
        bus(1'h1, 8'h00, 32'h00000041);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
    endtask : t_single
    task automatic t_standby();
        stby <= 1'h1;
        code <= ACEI_RES_ZERO;
        bus(1'h1, 8'h00, 32'h00000061);
        repeat (200) @(posedge mclk);
        bus(1'h0, 8'h04, 32'h0);
        chk(rd, {22'h0, ACEI_RES_FULL});
        stby <= 1'h0;
        wait_flag();
        bus(1'h0, 8'h04, 32'h0);
        chk(rd, {22'h0, ACEI_RES_ZERO});
        chk(acts, 2);
    endtask : t_standby
    task automatic t_scan();
        code <= 10'h155;
        bus(1'h0, 8'h00, 32'h0);
        bus(1'h1, 8'h00, 32'h00000074);
        repeat (250) @(posedge mclk);
        bus(1'h0, 8'h00, 32'h0);
        chk({31'h0, rd[7]}, 32'h0);
        wait_flag();
        for (int n = 4; n < 8; n++) begin
            bus(1'h0, 8'h08 | 8'(n << 4), 32'h0);
            chk(rd, 32'h00000155);
        end
        chk(acts, 3);
        bus(1'h1, 8'h00, 32'h0);
        stby <= 1'h1;
        repeat (4) @(posedge mclk);
        bus(1'h0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        stby <= 1'h0;
    endtask : t_scan
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        t_stop();
        t_single();
        t_standby();
        t_scan();
        complete_run();
    end
endmodule : tb_adc_conversion_end_interrupt
